// ==== src/sctf_map.svh ====
`ifndef SCTF_MAP_SVH
`define SCTF_MAP_SVH

// task-file offsets inside the common memory window
`define SCTF_OFF_DATA 4'h0
`define SCTF_OFF_ERRFEAT 4'h1
`define SCTF_OFF_COUNT 4'h2
`define SCTF_OFF_SECTOR 4'h3
`define SCTF_OFF_TRKLO 4'h4
`define SCTF_OFF_TRKHI 4'h5
`define SCTF_OFF_HEAD 4'h6
`define SCTF_OFF_STATCMD 4'h7
`define SCTF_OFF_DUP_EVEN 4'h8
`define SCTF_OFF_DUP_ODD 4'h9
`define SCTF_OFF_DUP_ERR 4'hd
`define SCTF_OFF_ALTCTL 4'he
`define SCTF_OFF_DRVADDR 4'hf
// memory window high half folds onto offsets 8/9
`define SCTF_OFF_HIGH_BASE 3'h4
// control-block address of alternate status in ide mode
`define SCTF_IDE_ALT 3'h6

// fault detail bit positions
`define SCTF_ERR_BBK 7
`define SCTF_ERR_UNC 6
`define SCTF_ERR_MISSING 4
`define SCTF_ERR_ABORTED 2
`define SCTF_ERR_GENERAL 0
`define SCTF_ERR_ZERO_MASK 8'h2a

// unit/head and device control fields
`define SCTF_HEAD_LBA 6
`define SCTF_HEAD_DRV 4
`define SCTF_CTL_SRST 2
`define SCTF_CTL_NIEN 1

// reset values and counts
`define SCTF_RST_BYTE 8'h00
`define SCTF_RST_HEAD 8'ha0
`define SCTF_SECTORS_MAX 9'h100

`endif

// ==== src/sctf_pkg.sv ====
package sctf_pkg;

  // register picked by the address decode
  typedef enum logic [3:0] {
    SCTF_R_NONE = 4'h0,
    SCTF_R_DATA = 4'h1,
    SCTF_R_ERRFEAT = 4'h2,
    SCTF_R_COUNT = 4'h3,
    SCTF_R_SECTOR = 4'h4,
    SCTF_R_TRKLO = 4'h5,
    SCTF_R_TRKHI = 4'h6,
    SCTF_R_HEAD = 4'h7,
    SCTF_R_STATCMD = 4'h8,
    SCTF_R_ALTCTL = 4'h9,
    SCTF_R_DRVADDR = 4'ha
  } sctf_reg_t;

  // byte lanes of the data bus used by one access
  typedef enum logic [1:0] {
    SCTF_LN_NONE = 2'h0,
    SCTF_LN_WORD = 2'h1,
    SCTF_LN_LO = 2'h2,
    SCTF_LN_HI = 2'h3
  } sctf_lane_t;

  // host access sequencer
  typedef enum logic [1:0] {
    SCTF_A_IDLE = 2'h0,
    SCTF_A_RD = 2'h1,
    SCTF_A_WR = 2'h2
  } sctf_acc_t;

  typedef struct packed {
    sctf_acc_t acc;
    sctf_reg_t sel;
    sctf_lane_t lane;
    logic odd;
    logic [15:0] wdata;
    logic [15:0] dout;
    logic [1:0] doe;
    logic pop;
    logic push;
    logic [15:0] wword;
    logic [7:0] even_b;
    logic [7:0] rd_hi;
    logic phase;
    logic byte_mode;
    logic [7:0] count;
    logic [8:0] total;
    logic [7:0] sector, trklo, trkhi, head, feat, opcode, devctl, err;
    logic cmd_stb;
    logic err_stat;
  } sctf_state_t;

endpackage: sctf_pkg

// ==== src/sctf_sync.sv ====
`timescale 1ns/1ps
module sctf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sctf_sync_t;

  sctf_sync_t q;
  sctf_sync_t d;

  // stage one feeds only stage two, never any logic
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  // reset to ones: idle strobes are high, so no false access
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;

endmodule: sctf_sync

// ==== src/sctf_decode.sv ====
`timescale 1ns/1ps
`include "sctf_map.svh"
module sctf_decode
  import sctf_pkg::*;
(
  input wire logic ide_mode,
  input wire logic reg_n,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic dmack_n,
  input wire logic [10:0] addr,
  input wire logic byte_mode,
  input wire logic byte_phase,
  output sctf_reg_t sel,
  output sctf_lane_t lane,
  output logic odd
);

  // offset to register; both windows share it
  function automatic sctf_reg_t sctf_off2reg(input logic [3:0] off);
    case (off)
      `SCTF_OFF_DATA, `SCTF_OFF_DUP_EVEN, `SCTF_OFF_DUP_ODD:
        sctf_off2reg = SCTF_R_DATA;
      `SCTF_OFF_ERRFEAT, `SCTF_OFF_DUP_ERR: sctf_off2reg = SCTF_R_ERRFEAT;
      `SCTF_OFF_COUNT: sctf_off2reg = SCTF_R_COUNT;
      `SCTF_OFF_SECTOR: sctf_off2reg = SCTF_R_SECTOR;
      `SCTF_OFF_TRKLO: sctf_off2reg = SCTF_R_TRKLO;
      `SCTF_OFF_TRKHI: sctf_off2reg = SCTF_R_TRKHI;
      `SCTF_OFF_HEAD: sctf_off2reg = SCTF_R_HEAD;
      `SCTF_OFF_STATCMD: sctf_off2reg = SCTF_R_STATCMD;
      `SCTF_OFF_ALTCTL: sctf_off2reg = SCTF_R_ALTCTL;
      `SCTF_OFF_DRVADDR: sctf_off2reg = SCTF_R_DRVADDR;
      default: sctf_off2reg = SCTF_R_NONE;
    endcase
  endfunction: sctf_off2reg

  logic [3:0] off;

  // lane none means the card is not addressed at all
  always_comb begin
    off = 4'h0;
    sel = SCTF_R_NONE;
    lane = SCTF_LN_NONE;
    odd = 1'b0;
    if (ide_mode) begin
      if (cs1_n && !cs0_n && dmack_n) begin
        sel = sctf_off2reg({1'b0, addr[2:0]});
        lane = SCTF_LN_LO;
        if (sel == SCTF_R_DATA) begin
          lane = byte_mode ? SCTF_LN_LO : SCTF_LN_WORD;
          odd = byte_mode & byte_phase;
        end
      end else if (!cs1_n && cs0_n && dmack_n) begin
        if (addr[2:0] == `SCTF_IDE_ALT) begin
          sel = SCTF_R_ALTCTL;
          lane = SCTF_LN_LO;
        end
      end else if (cs1_n && cs0_n && !dmack_n) begin
        sel = SCTF_R_DATA;
        lane = SCTF_LN_WORD;
      end
    end else if (reg_n && !(ce1_n && ce2_n)) begin
      // a10 high: every address folds onto the data port
      off = addr[10] ? {`SCTF_OFF_HIGH_BASE, addr[0]} : addr[3:0];
      sel = sctf_off2reg(off);
      if (!ce1_n && !ce2_n) begin
        odd = 1'b0;
        if (off == `SCTF_OFF_DUP_ERR) begin
          lane = SCTF_LN_HI;
        end else begin
          lane = (sel == SCTF_R_DATA) ? SCTF_LN_WORD : SCTF_LN_LO;
        end
      end else if (!ce1_n) begin
        lane = SCTF_LN_LO;
        odd = off[0];
      end else begin
        lane = SCTF_LN_HI;
        odd = 1'b1;
        if (off == `SCTF_OFF_DATA) begin
          sel = SCTF_R_ERRFEAT;
        end
      end
    end
  end

endmodule: sctf_decode

// ==== src/sctf_top.sv ====
// Function
// - memory mode, A10 low: A3-A0 pick offsets 0-Fh, A9-A4 ignored.
// - memory mode, A10 high: all go to data port, A0 picks byte.
// - ide mode chip selects and A2-A0 pick task file or alt status.
// - dma acknowledge with both selects high moves one data word.
// - data port is 16 bits; word access on D15-D0 at 0, 8, 9.
// - byte data lanes follow the card enables and A0.
// - memory decode only answers with the attribute select high.
// - ide mode offers byte-wide data path chosen by a feature command.
// - read offset 0 on high lane only returns fault detail on D15-D8.
// - option select is write-only, shares 1 and Dh, high-lane offset 0.
// - fault detail is read-only; bits 5, 3 and 1 stay zero.
// - bit 7 set on bad block or interface crc error.
// - bit 6 set on uncorrectable data error.
// - bit 4 set when the sector id is bad or missing.
// - bit 2 set when a command is aborted.
// - bit 0 set on a general error.
// - transfer count zero means 256 sectors.
// - count goes to zero on success, holds remainder on failure.
// - start sector is chs sector or block address bits 7-0.
// - status bit 0 set when a command ended in error.
// - block address 15-8 from track low, 23-16 from track high.
`timescale 1ns/1ps
`include "sctf_map.svh"
module sctf_top
  import sctf_pkg::*;
#(
  parameter logic [7:0] SETFEAT_OP = 8'hef,
  parameter logic [7:0] FEAT_BYTE_ON = 8'h01,
  parameter logic [7:0] FEAT_BYTE_OFF = 8'h81
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ide_mode,
  input wire logic reg_n,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic cs0_n,
  input wire logic cs1_n,
  input wire logic dmack_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] d_in,
  output logic [15:0] d_out,
  output logic [1:0] d_oe,
  input wire logic [15:0] buf_rd_data,
  output logic buf_pop,
  output logic [15:0] buf_wr_data,
  output logic buf_push,
  input wire logic [7:2] core_status,
  input wire logic evt_bad_block,
  input wire logic evt_iface_crc,
  input wire logic evt_uncorrectable,
  input wire logic evt_sector_missing,
  input wire logic evt_aborted,
  input wire logic evt_general,
  input wire logic sector_done,
  input wire logic cmd_done,
  input wire logic cmd_ok,
  output logic cmd_strobe,
  output logic [7:0] cmd_code,
  output logic [7:0] option_value,
  output logic [8:0] sector_total,
  output logic [27:0] target_addr,
  output logic lba_mode,
  output logic soft_reset,
  output logic irq_disable
);

  localparam int PW = 38;
  localparam sctf_state_t RST_S = '{
    acc: SCTF_A_IDLE,
    sel: SCTF_R_NONE,
    lane: SCTF_LN_NONE,
    head: `SCTF_RST_HEAD,
    total: `SCTF_SECTORS_MAX,
    default: '0
  };

  sctf_state_t q;
  sctf_state_t d;
  logic [PW-1:0] pin_s;
  logic s_ide, s_reg_n, s_ce1_n, s_ce2_n, s_oe_n, s_we_n;
  logic s_iord_n, s_iowr_n, s_cs0_n, s_cs1_n, s_dmack_n;
  logic [10:0] s_addr;
  logic [15:0] s_d;
  logic rd_act;
  logic wr_act;
  sctf_reg_t dec_sel;
  sctf_lane_t dec_lane;
  logic dec_odd;
  logic [7:0] status_view;
  logic [7:0] drv_view;

  // every pin crosses two flops before the sequencer sees it
  sctf_sync #(.W(PW)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({ide_mode, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n,
          cs0_n, cs1_n, dmack_n, addr, d_in}),
    .dout(pin_s)
  );

  assign {s_ide, s_reg_n, s_ce1_n, s_ce2_n, s_oe_n, s_we_n, s_iord_n,
          s_iowr_n, s_cs0_n, s_cs1_n, s_dmack_n, s_addr, s_d} = pin_s;

  // strobe pair depends on the interface mode
  assign rd_act = s_ide ? !s_iord_n : !s_oe_n;
  assign wr_act = s_ide ? !s_iowr_n : !s_we_n;

  sctf_decode u_decode (
    .ide_mode(s_ide),
    .reg_n(s_reg_n),
    .ce1_n(s_ce1_n),
    .ce2_n(s_ce2_n),
    .cs0_n(s_cs0_n),
    .cs1_n(s_cs1_n),
    .dmack_n(s_dmack_n),
    .addr(s_addr),
    .byte_mode(q.byte_mode),
    .byte_phase(q.phase),
    .sel(dec_sel),
    .lane(dec_lane),
    .odd(dec_odd)
  );

  // read views; bit 1 of status is always zero
  assign status_view = {core_status, 1'b0, q.err_stat};
  assign drv_view = {1'b0, 1'b1, ~q.head[3:0], ~q.head[`SCTF_HEAD_DRV],
                     q.head[`SCTF_HEAD_DRV]};

  // host access sequencer, register file and core event merge
  always_comb begin
    logic [7:0] wb;
    logic [7:0] rb;
    wb = (q.lane == SCTF_LN_HI) ? q.wdata[15:8] : q.wdata[7:0];
    rb = 8'h00;
    d = q;
    d.pop = 1'b0;
    d.push = 1'b0;
    d.cmd_stb = 1'b0;
    case (q.acc)
      SCTF_A_IDLE: begin
        if (rd_act && dec_lane != SCTF_LN_NONE) begin
          d.acc = SCTF_A_RD;
          d.sel = dec_sel;
          d.lane = dec_lane;
          d.odd = dec_odd;
          case (dec_sel)
            SCTF_R_DATA: rb = dec_odd ? q.rd_hi : buf_rd_data[7:0];
            SCTF_R_ERRFEAT: rb = q.err;
            SCTF_R_COUNT: rb = q.count;
            SCTF_R_SECTOR: rb = q.sector;
            SCTF_R_TRKLO: rb = q.trklo;
            SCTF_R_TRKHI: rb = q.trkhi;
            SCTF_R_HEAD: rb = q.head;
            SCTF_R_STATCMD, SCTF_R_ALTCTL: rb = status_view;
            SCTF_R_DRVADDR: rb = drv_view;
            default: rb = 8'h00;
          endcase
          case (dec_lane)
            SCTF_LN_WORD: begin
              d.dout = (dec_sel == SCTF_R_DATA) ? buf_rd_data
                                               : {8'h00, rb};
              d.doe = 2'b11;
            end
            SCTF_LN_HI: begin
              d.dout = {rb, 8'h00};
              d.doe = 2'b10;
            end
            default: begin
              d.dout = {8'h00, rb};
              d.doe = 2'b01;
            end
          endcase
          // even byte fetches the word, odd byte reuses its top half
          if (dec_sel == SCTF_R_DATA) begin
            if (dec_lane == SCTF_LN_WORD) begin
              d.pop = 1'b1;
            end else begin
              d.phase = ~q.phase;
              if (!dec_odd) begin
                d.pop = 1'b1;
                d.rd_hi = buf_rd_data[15:8];
              end
            end
          end
        end else if (wr_act && dec_lane != SCTF_LN_NONE) begin
          d.acc = SCTF_A_WR;
          d.sel = dec_sel;
          d.lane = dec_lane;
          d.odd = dec_odd;
          d.wdata = s_d;
        end
      end
      SCTF_A_RD: begin
        if (!rd_act) begin
          d.acc = SCTF_A_IDLE;
          d.doe = 2'b00;
        end
      end
      SCTF_A_WR: begin
        // data is taken from the last cycle the strobe was low
        if (wr_act) begin
          d.wdata = s_d;
        end else begin
          d.acc = SCTF_A_IDLE;
          case (q.sel)
            SCTF_R_DATA: begin
              if (q.lane == SCTF_LN_WORD) begin
                d.push = 1'b1;
                d.wword = q.wdata;
              end else begin
                d.phase = ~q.phase;
                if (!q.odd) begin
                  d.even_b = wb;
                end else begin
                  d.push = 1'b1;
                  d.wword = {wb, q.even_b};
                end
              end
            end
            SCTF_R_ERRFEAT: d.feat = wb;
            SCTF_R_COUNT: d.count = wb;
            SCTF_R_SECTOR: d.sector = wb;
            SCTF_R_TRKLO: d.trklo = wb;
            SCTF_R_TRKHI: d.trkhi = wb;
            SCTF_R_HEAD: d.head = wb;
            SCTF_R_STATCMD: begin
              d.opcode = wb;
              d.cmd_stb = 1'b1;
              d.err = `SCTF_RST_BYTE;
              d.err_stat = 1'b0;
              d.phase = 1'b0;
              if (wb == SETFEAT_OP && q.feat == FEAT_BYTE_ON) begin
                d.byte_mode = 1'b1;
              end
              if (wb == SETFEAT_OP && q.feat == FEAT_BYTE_OFF) begin
                d.byte_mode = 1'b0;
              end
            end
            SCTF_R_ALTCTL: d.devctl = wb;
            default: d.wdata = q.wdata;
          endcase
        end
      end
      default: d.acc = SCTF_A_IDLE;
    endcase
    // core events come last so a set beats a command clear
    if (evt_bad_block || evt_iface_crc) begin
      d.err[`SCTF_ERR_BBK] = 1'b1;
    end
    if (evt_uncorrectable) begin
      d.err[`SCTF_ERR_UNC] = 1'b1;
    end
    if (evt_sector_missing) begin
      d.err[`SCTF_ERR_MISSING] = 1'b1;
    end
    if (evt_aborted) begin
      d.err[`SCTF_ERR_ABORTED] = 1'b1;
    end
    if (evt_general) begin
      d.err[`SCTF_ERR_GENERAL] = 1'b1;
    end
    // zero wraps to 255, which is 256 minus one
    if (sector_done) begin
      d.count = d.count - 8'h01;
    end
    if (cmd_done) begin
      if (cmd_ok) begin
        d.count = 8'h00;
      end else begin
        d.err_stat = 1'b1;
      end
    end
    d.total = (d.count == 8'h00) ? `SCTF_SECTORS_MAX
                                 : {1'b0, d.count};
  end

  // single register stage for all state
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign d_out = q.dout;
  assign d_oe = q.doe;
  assign buf_pop = q.pop;
  assign buf_wr_data = q.wword;
  assign buf_push = q.push;
  assign cmd_strobe = q.cmd_stb;
  assign cmd_code = q.opcode;
  assign option_value = q.feat;
  assign sector_total = q.total;
  assign target_addr = {q.head[3:0], q.trkhi, q.trklo, q.sector};
  assign lba_mode = q.head[`SCTF_HEAD_LBA];
  assign soft_reset = q.devctl[`SCTF_CTL_SRST];
  assign irq_disable = q.devctl[`SCTF_CTL_NIEN];

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  a_err_zero_bits: assert property (
    (q.err & `SCTF_ERR_ZERO_MASK) == 8'h00)
    else $error("reserved fault bits set");
  a_bbk_sets: assert property (
    (evt_bad_block || evt_iface_crc) |=> q.err[`SCTF_ERR_BBK])
    else $error("bad block flag missed");
  a_unc_sets: assert property (
    evt_uncorrectable |=> q.err[`SCTF_ERR_UNC])
    else $error("uncorrectable flag missed");
  a_missing_sets: assert property (
    evt_sector_missing |=> q.err[`SCTF_ERR_MISSING])
    else $error("sector missing flag missed");
  a_abort_sets: assert property (
    evt_aborted |=> q.err[`SCTF_ERR_ABORTED])
    else $error("aborted flag missed");
  a_general_sets: assert property (
    evt_general |=> q.err[`SCTF_ERR_GENERAL])
    else $error("general fault flag missed");
  a_zero_count_full: assert property (
    (q.count == 8'h00) |-> (sector_total == 9'h100))
    else $error("zero count not 256");
  a_done_count_zero: assert property (
    (cmd_done && cmd_ok) |=> (q.count == 8'h00))
    else $error("count not zero after success");
  a_fail_status: assert property (
    (cmd_done && !cmd_ok) |=> q.err_stat ##0 status_view[0])
    else $error("error status not set");
  a_read_release: assert property (
    (q.acc == SCTF_A_RD && !rd_act) |=> (d_oe == 2'b00))
    else $error("bus still driven after read");
  a_push_once: assert property (
    buf_push |=> !buf_push)
    else $error("double push for one write");
  a_word_pop: assert property (
    (q.acc == SCTF_A_IDLE && rd_act && dec_sel == SCTF_R_DATA &&
     dec_lane == SCTF_LN_WORD) |=> buf_pop && d_oe == 2'b11 ##1 !buf_pop)
    else $error("word read did not pop once");

  c_word_read: cover property (buf_pop && d_oe == 2'b11);
  c_byte_pair: cover property (buf_push && q.lane != SCTF_LN_WORD);
  c_cmd_write: cover property (cmd_strobe);
  c_fail_done: cover property (cmd_done && !cmd_ok);

endmodule: sctf_top

// ==== sim/sctf_buf_model.sv ====
`timescale 1ns/1ps
module sctf_buf_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic buf_pop,
  input wire logic buf_push,
  input wire logic [15:0] buf_wr_data,
  output logic [15:0] buf_rd_data,
  output logic [15:0] last_wr,
  output logic [7:0] pop_cnt
);
  // fall-through head word steps on every pop so a double pop shows
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_rd_data <= 16'h1234;
      pop_cnt <= 8'h00;
      last_wr <= 16'h0000;
    end else begin
      if (buf_pop) begin
        buf_rd_data <= buf_rd_data + 16'h1111;
        pop_cnt <= pop_cnt + 8'h01;
      end
      if (buf_push) begin
        last_wr <= buf_wr_data;
      end
    end
  end
endmodule: sctf_buf_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
  import sctf_pkg::*;
  logic clk = 0, rst = 1, ide = 0, reg_n = 1, ce1_n = 1, ce2_n = 1;
  logic oe_n = 1, we_n = 1, iord_n = 1, iowr_n = 1;
  logic cs0_n = 1, cs1_n = 1, dmack_n = 1;
  logic [10:0] addr = 11'h000;
  logic [15:0] d_in = 16'h0000, rd_v, w = 16'h1234;
  logic [5:0] core_st = 6'h14;
  logic [8:0] cv = 9'h000;
  logic [1:0] oe_v;
  logic [7:0] ncmd = 8'h00;
  wire [15:0] d_out, brd, bwr, last_wr;
  wire [1:0] d_oe;
  wire bpop, bpush, cmd_strobe, lba_mode, srst, nien;
  wire [7:0] cmd_code, option_value, pop_cnt;
  wire [8:0] sector_total;
  wire [27:0] target_addr;
  int fail_count = 0, n_checks = 0, cyc = 0, npop = 0;
  // lane selects: {ce2_n,ce1_n} in memory mode, {cs1_n,cs0_n} in ide
  localparam logic [1:0] W = 2'h0, LO = 2'h2, HI = 2'h1;
  localparam logic [1:0] TF = 2'h2, CB = 2'h1, DM = 2'h3;
  localparam logic [7:0] DET [6] = '{8'h80, 8'h80, 8'h40, 8'h10, 8'h04, 8'h01};

  always #50 clk = ~clk;

  sctf_top sctf_top_inst (.clk(clk), .rst(rst), .ide_mode(ide), .reg_n(reg_n),
    .ce1_n(ce1_n), .ce2_n(ce2_n), .oe_n(oe_n), .we_n(we_n),
    .iord_n(iord_n), .iowr_n(iowr_n), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .dmack_n(dmack_n), .addr(addr), .d_in(d_in), .d_out(d_out),
    .d_oe(d_oe), .buf_rd_data(brd), .buf_pop(bpop), .buf_wr_data(bwr),
    .buf_push(bpush), .core_status(core_st), .evt_bad_block(cv[5]),
    .evt_iface_crc(cv[4]), .evt_uncorrectable(cv[3]),
    .evt_sector_missing(cv[2]), .evt_aborted(cv[1]), .evt_general(cv[0]),
    .sector_done(cv[8]), .cmd_done(cv[7]), .cmd_ok(cv[6]),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .option_value(option_value), .sector_total(sector_total),
    .target_addr(target_addr), .lba_mode(lba_mode), .soft_reset(srst),
    .irq_disable(nien));

  sctf_buf_model sctf_buf_model_inst (.clk(clk), .rst(rst), .buf_pop(bpop),
    .buf_push(bpush), .buf_wr_data(bwr), .buf_rd_data(brd),
    .last_wr(last_wr), .pop_cnt(pop_cnt));

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask: results

  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // one pulse per command write, so a repeat or a miss shows
    if (cmd_strobe) ncmd <= ncmd + 8'h01;
    if (cyc == 6000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk(input string n, input logic [27:0] s, e);
    n_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask: chk

  // one strobe cycle: selects settle, strobe low 6 clocks, high 5 clocks
  task automatic acc(input logic wr, input logic [1:0] sel,
                     input logic [10:0] a, input logic [15:0] wd);
    @(posedge clk);
    {ce2_n, ce1_n} <= ide ? 2'h3 : sel;
    {cs1_n, cs0_n} <= ide ? sel : 2'h3;
    dmack_n <= !(ide && sel == DM);
    addr <= a;
    d_in <= wd;
    repeat (3) @(posedge clk);
    if (ide) begin
      if (wr) iowr_n <= 1'b0;
      else iord_n <= 1'b0;
    end else begin
      if (wr) we_n <= 1'b0;
      else oe_n <= 1'b0;
    end
    repeat (5) @(posedge clk);
    #1;
    rd_v = d_out;
    oe_v = d_oe;
    @(posedge clk);
    {oe_n, we_n, iord_n, iowr_n} <= 4'hf;
    repeat (5) @(posedge clk);
  endtask: acc

  task automatic wr(input logic [1:0] sel, input logic [10:0] a,
                    input logic [15:0] wd);
    acc(1'b1, sel, a, wd);
  endtask: wr

  task automatic rdc(input string n, input logic [1:0] sel,
                     input logic [10:0] a, input logic [15:0] e,
                     input logic [1:0] eo);
    logic [15:0] m;
    m = {{8{eo[1]}}, {8{eo[0]}}};
    acc(1'b0, sel, a, 16'h0000);
    chk(n, rd_v & m, e);
    chk({n, "_oe"}, oe_v, eo);
  endtask: rdc

  task automatic pul(input logic [8:0] v);
    @(posedge clk);
    cv <= v;
    @(posedge clk);
    cv <= 9'h000;
    repeat (2) @(posedge clk);
  endtask: pul

  task automatic adv();
    w = w + 16'h1111;
    npop++;
  endtask: adv

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("idle_oe", d_oe, 2'h0);
    chk("total", sector_total, 9'h100);
    rdc("count", LO, 11'h002, 16'h0000, 2'h1);
    rdc("head", LO, 11'h006, 16'h00a0, 2'h1);
    rdc("detail", LO, 11'h001, 16'h0000, 2'h1);
    $display("test reset done");
    // upper address bits must not disturb the task-file decode
    wr(LO, 11'h3f3, 16'h005a);
    wr(LO, 11'h004, 16'h0022);
    wr(LO, 11'h005, 16'h0033);
    wr(LO, 11'h006, 16'h00e3);
    rdc("sector", LO, 11'h003, 16'h005a, 2'h1);
    chk("target", target_addr, 28'h333225a);
    chk("lba", lba_mode, 1'b1);
    rdc("drv", LO, 11'h00f, 16'h0072, 2'h1);
    reg_n <= 1'b0;
    rdc("reg_low", LO, 11'h003, 16'h0000, 2'h0);
    reg_n <= 1'b1;
    wr(LO, 11'h00a, 16'h0077);
    rdc("unmapped", LO, 11'h00a, 16'h0000, 2'h1);
    $display("test decode done");
    // data port: word, byte pair, high-lane odd, writes
    rdc("word", W, 11'h400, w, 2'h3);
    adv();
    rdc("even", LO, 11'h7f8, w & 16'h00ff, 2'h1);
    rdc("odd", LO, 11'h401, w >> 8, 2'h1);
    rdc("odd_hi", HI, 11'h009, w & 16'hff00, 2'h2);
    adv();
    wr(W, 11'h408, 16'hbeef);
    chk("push_word", last_wr, 16'hbeef);
    wr(LO, 11'h400, 16'h0011);
    wr(LO, 11'h401, 16'h0022);
    chk("push_bytes", last_wr, 16'h2211);
    $display("test data done");
    // each error source sets its fault bit, bad block and crc both bit 7; the failed completion sets the status error bit
    for (int i = 0; i < 6; i++) begin
      wr(LO, 11'h007, 16'h0000);
      chk("op", cmd_code, 8'h00);
      // failed completion together with the source, as the core reports it
      pul({3'h2, 6'h20 >> i});
      rdc("detail", LO, 11'h001, {8'h00, DET[i]}, 2'h1);
      rdc("status", LO, 11'h007, 16'h0051, 2'h1);
    end
    pul(9'h03f);
    rdc("det_all", LO, 11'h001, 16'h00d5, 2'h1);
    rdc("det_hi", HI, 11'h000, 16'hd500, 2'h2);
    wr(HI, 11'h000, 16'h3c00);
    chk("opt_hi", option_value, 8'h3c);
    wr(LO, 11'h00d, 16'h007e);
    chk("opt_dup", option_value, 8'h7e);
    rdc("det_dup", LO, 11'h00d, 16'h00d5, 2'h1);
    rdc("det_wd", W, 11'h00d, 16'hd500, 2'h2);
    $display("test fault done");
    // count: zero means 256, remainder held on failure, zero on success
    wr(LO, 11'h002, 16'h0000);
    chk("total0", sector_total, 9'h100);
    wr(LO, 11'h002, 16'h0003);
    pul(9'h100);
    chk("total2", sector_total, 9'h002);
    pul(9'h080);
    rdc("cnt_fail", LO, 11'h002, 16'h0002, 2'h1);
    pul(9'h0c0);
    rdc("cnt_ok", LO, 11'h002, 16'h0000, 2'h1);
    wr(LO, 11'h007, 16'h0000);
    $display("test count done");
    // ide mode selects, dma word and byte-wide data path
    ide <= 1'b1;
    wr(TF, 11'h002, 16'h0009);
    rdc("ide_cnt", TF, 11'h002, 16'h0009, 2'h1);
    rdc("ide_alt", CB, 11'h006, 16'h0050, 2'h1);
    rdc("dma", DM, 11'h7ff, w, 2'h3);
    adv();
    wr(TF, 11'h001, 16'h0001);
    wr(TF, 11'h007, 16'h00ef);
    chk("setfeat", cmd_code, 8'hef);
    rdc("b_even", TF, 11'h000, w & 16'h00ff, 2'h1);
    rdc("b_odd", TF, 11'h000, w >> 8, 2'h1);
    adv();
    wr(TF, 11'h001, 16'h0081);
    wr(TF, 11'h007, 16'h00ef);
    rdc("pio_word", TF, 11'h000, w, 2'h3);
    adv();
    chk("pops", pop_cnt, npop[7:0]);
    wr(CB, 11'h006, 16'h0006);
    chk("srst", srst, 1'b1);
    chk("nien", nien, 1'b1);
    chk("cmds", ncmd, 8'h09);
    $display("test ide done");
    results();
  end
endmodule: tb
